// ### hw/gei_pkg.sv
/*
  package for the port-pin and edge-interrupt register block:
  register indices, field positions, reset values and the serial frame layout.
  assumes a 64-bit serial frame framed by a one-bit-clock sync pulse.
*/
package gei_pkg;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam int unsigned REG_AW                  = 4;
  localparam logic [3:0]  REG_PORT_PIN_DATA       = 4'h0;
  localparam logic [3:0]  REG_PORT_PIN_DIRECTION  = 4'h1;
  localparam logic [3:0]  REG_RISING_EDGE_ENABLE  = 4'h2;
  localparam logic [3:0]  REG_FALLING_EDGE_ENABLE = 4'h3;
  localparam logic [3:0]  REG_INT_CLEAR_STATUS    = 4'h4;
  localparam logic [15:0] REG_RESET               = 16'h0000;

  // ****************************************************************
  // field layout
  // ****************************************************************
  localparam int unsigned PORT_W            = 10;
  localparam int unsigned SRC_W             = 16;
  localparam int unsigned ZERO_SELECT_BIT   = 15;
  localparam int unsigned CONV_DONE_BIT     = 11;
  localparam int unsigned PLUS_X_BIT        = 12;
  localparam int unsigned MINUS_X_BIT       = 13;
  localparam int unsigned TEL_CLIP_BIT      = 14;
  localparam int unsigned AUD_CLIP_BIT      = 15;
  localparam logic [15:0] SRC_MASK          = 16'hFBFF;
  localparam logic [15:0] DIR_MASK          = 16'h83FF;

  // ****************************************************************
  // serial frame: bit 0 write flag, bits 1-4 index, bits 16-31 data
  // ****************************************************************
  localparam int unsigned FRM_BITS          = 64;
  localparam logic [5:0]  FRM_ADDR_LAST     = 6'd4;
  localparam logic [5:0]  FRM_LOAD_READ     = 6'd15;
  localparam logic [5:0]  FRM_DATA_LAST     = 6'd31;
  localparam logic [5:0]  FRM_LAST          = 6'd63;
  // update lands about this many bit clocks after the sync edge
  localparam int unsigned WRITE_SETTLE_T    = 65;

  typedef struct packed {
    logic              write;
    logic [REG_AW-1:0] addr;
    logic [15:0]       data;
  } gei_req_t;

endpackage

// ### hw/gei_top.sv
/*
  port-pin data/direction registers and edge-triggered interrupt unit,
  reached over a four-wire serial frame on its own bit clock.
  assumes sync and data-in are launched on the link clock by the controller
  and that the link clock runs through the whole 64-bit frame.
*/
// Summary of operation
// - pins set as outputs drive the last written port data bits
// - reading port data returns present pin levels, not written values
// - direction bit one makes a pin output; all reset to input
// - zero select set drives serial data output low in second word
// - zero select clear, the reset value, leaves output released in word two
// - rise enable bits 0-9 let a rising pin edge raise its interrupt
// - rise enables at bits 11-15 for converter, sense lines and clips
// - fall enable bits 0-9 let a falling pin edge raise its interrupt
// - fall enables at bits 11-15 likewise; bit 10 unused in both
// - a zero-to-one written bit 0-9 clears that pin's pending event
// - reading status bits 0-9 returns pending pin events
// - zero-to-one on bit 11 clears the converter-done event
// - zero-to-one on bits 12 and 13 clear the sense line events
// - status bits 11-13 read converter and sense line pending state
// - bits 14 and 15 report and clear the clip events likewise
// - a written register takes effect about 65 bit clocks after sync
`timescale 1ns/1ps
module gei_top
  import gei_pkg::*;
(
  // system clock and reset
  input  wire logic              i_sys_clk,
  input  wire logic              i_rst_b,
  // serial link
  input  wire logic              i_link_clk,
  input  wire logic              i_serial_frame_sync,
  input  wire logic              i_serial_data_in,
  output logic                   o_serial_data_output,
  output logic                   o_serial_data_output_oe,
  // port pins
  input  wire logic [PORT_W-1:0] i_port_pin,
  output logic      [PORT_W-1:0] o_port_pin_out,
  output logic      [PORT_W-1:0] o_port_pin_oe,
  // interrupt sources
  input  wire logic              i_converter_done,
  input  wire logic              i_touch_plus_x_sense,
  input  wire logic              i_touch_minus_x_sense,
  input  wire logic              i_telecom_clip,
  input  wire logic              i_audio_clip,
  // interrupt output
  output logic                   o_irq
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  logic [SRC_W-1:0]  src_raw;
  logic [SRC_W-1:0]  src_s1_q;
  logic [SRC_W-1:0]  src_s2_q;
  logic [SRC_W-1:0]  src_prev_q;
  logic [SRC_W-1:0]  edge_ev;
  logic [15:0]       data_q;
  logic [15:0]       dir_q;
  logic [15:0]       rise_q;
  logic [15:0]       fall_q;
  logic [15:0]       clr_wr_q;
  logic [15:0]       stat_q;
  logic [15:0]       stat_d;
  logic [15:0]       clr_pulse;
  logic [15:0]       hold_q;
  logic              ack_tgl_q;
  logic [2:0]        rreq_sync_q;
  logic [2:0]        wreq_sync_q;
  logic              wr_stb;
  logic              rd_stb;
  // link domain
  logic [1:0]        lrst_q;
  logic              lrst_b;
  logic              act_q;
  logic [5:0]        cnt_q;
  gei_req_t          req_q;
  logic [15:0]       sh_q;
  logic              rreq_tgl_q;
  logic              wreq_tgl_q;
  logic [1:0]        ack_sync_q;
  logic [1:0]        zsel_sync_q;
  logic [15:0]       out_sh_q;
  logic              dout_q;
  logic              doe_q;

  function automatic logic [15:0] read_mux(input logic [REG_AW-1:0] a,
                                           input logic [15:0] pins,
                                           input logic [15:0] dir,
                                           input logic [15:0] rise,
                                           input logic [15:0] fall,
                                           input logic [15:0] stat);
    logic [15:0] r;
    r = 16'h0000;
    unique case (a)
      REG_PORT_PIN_DATA:       r = pins & 16'h03FF;
      REG_PORT_PIN_DIRECTION:  r = dir;
      REG_RISING_EDGE_ENABLE:  r = rise;
      REG_FALLING_EDGE_ENABLE: r = fall;
      REG_INT_CLEAR_STATUS:    r = stat;
      default:                 r = 16'h0000;
    endcase
    return r;
  endfunction

  // ****************************************************************
  // source capture and edge detection
  // ****************************************************************
  always_comb begin
    src_raw                = '0;
    src_raw[PORT_W-1:0]    = i_port_pin;
    src_raw[CONV_DONE_BIT] = i_converter_done;
    src_raw[PLUS_X_BIT]    = i_touch_plus_x_sense;
    src_raw[MINUS_X_BIT]   = i_touch_minus_x_sense;
    src_raw[TEL_CLIP_BIT]  = i_telecom_clip;
    src_raw[AUD_CLIP_BIT]  = i_audio_clip;
  end

  always_ff @(posedge i_sys_clk) begin
    src_s1_q <= src_raw;
    src_s2_q <= src_s1_q;
    if (!i_rst_b) begin
      src_prev_q <= '0;
    end else begin
      src_prev_q <= src_s2_q;
    end
  end

  // bit 10 has no source and no enable
  assign edge_ev = ((src_s2_q & ~src_prev_q & rise_q)
                 | (~src_s2_q & src_prev_q & fall_q)) & SRC_MASK;

  // ****************************************************************
  // requests crossing from the link domain
  // ****************************************************************
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      rreq_sync_q <= '0;
      wreq_sync_q <= '0;
    end else begin
      rreq_sync_q <= {rreq_sync_q[1:0], rreq_tgl_q};
      wreq_sync_q <= {wreq_sync_q[1:0], wreq_tgl_q};
    end
  end

  assign rd_stb = rreq_sync_q[2] ^ rreq_sync_q[1];
  assign wr_stb = wreq_sync_q[2] ^ wreq_sync_q[1];

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      hold_q    <= REG_RESET;
      ack_tgl_q <= 1'b0;
    end else if (rd_stb) begin
      hold_q    <= read_mux(req_q.addr, src_s2_q, dir_q, rise_q, fall_q,
                            stat_q);
      ack_tgl_q <= rreq_sync_q[1];
    end
  end

  // ****************************************************************
  // register file
  // ****************************************************************
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      data_q   <= REG_RESET;
      dir_q    <= REG_RESET;
      rise_q   <= REG_RESET;
      fall_q   <= REG_RESET;
      clr_wr_q <= REG_RESET;
    end else if (wr_stb) begin
      unique case (req_q.addr)
        REG_PORT_PIN_DATA:       data_q   <= req_q.data & 16'h03FF;
        REG_PORT_PIN_DIRECTION:  dir_q    <= req_q.data & DIR_MASK;
        REG_RISING_EDGE_ENABLE:  rise_q   <= req_q.data & SRC_MASK;
        REG_FALLING_EDGE_ENABLE: fall_q   <= req_q.data & SRC_MASK;
        REG_INT_CLEAR_STATUS:    clr_wr_q <= req_q.data & SRC_MASK;
        default:                 data_q   <= data_q;
      endcase
    end
  end

  // a clear needs a zero-to-one change against the last written value
  always_comb begin
    clr_pulse = '0;
    if (wr_stb && req_q.addr == REG_INT_CLEAR_STATUS) begin
      clr_pulse = req_q.data & ~clr_wr_q & SRC_MASK;
    end
  end

  // a new edge wins over a clear in the same cycle
  assign stat_d = (stat_q & ~clr_pulse) | edge_ev;

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      stat_q <= REG_RESET;
    end else begin
      stat_q <= stat_d;
    end
  end

  assign o_port_pin_out = data_q[PORT_W-1:0];
  assign o_port_pin_oe  = dir_q[PORT_W-1:0];
  assign o_irq          = |stat_q;

  // ****************************************************************
  // link domain: reset, frame counter and request capture
  // ****************************************************************
  always_ff @(posedge i_link_clk) begin
    lrst_q <= {lrst_q[0], i_rst_b};
  end

  assign lrst_b = lrst_q[1];

  always_ff @(posedge i_link_clk) begin
    if (!lrst_b) begin
      act_q <= 1'b0;
      cnt_q <= '0;
    end else if (i_serial_frame_sync) begin
      act_q <= 1'b1;
      cnt_q <= 6'd1;
    end else if (act_q) begin
      cnt_q <= cnt_q + 6'd1;
      if (cnt_q == FRM_LAST) begin
        act_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_link_clk) begin
    if (!lrst_b) begin
      req_q      <= '0;
      sh_q       <= '0;
      rreq_tgl_q <= 1'b0;
      wreq_tgl_q <= 1'b0;
    end else begin
      sh_q <= {sh_q[14:0], i_serial_data_in};
      if (i_serial_frame_sync) begin
        req_q.write <= i_serial_data_in;
      end else if (act_q) begin
        if (cnt_q == FRM_ADDR_LAST) begin
          req_q.addr <= {sh_q[2:0], i_serial_data_in};
          rreq_tgl_q <= ~rreq_tgl_q;
        end
        if (cnt_q == FRM_DATA_LAST) begin
          req_q.data <= {sh_q[14:0], i_serial_data_in};
        end
        // frame end hands the write over, 63 bit clocks after sync
        if (cnt_q == FRM_LAST && req_q.write) begin
          wreq_tgl_q <= ~wreq_tgl_q;
        end
      end
    end
  end

  // ****************************************************************
  // link domain: serial data output
  // ****************************************************************
  always_ff @(posedge i_link_clk) begin
    if (!lrst_b) begin
      ack_sync_q  <= '0;
      zsel_sync_q <= '0;
    end else begin
      ack_sync_q  <= {ack_sync_q[0], ack_tgl_q};
      zsel_sync_q <= {zsel_sync_q[0], dir_q[ZERO_SELECT_BIT]};
    end
  end

  always_ff @(posedge i_link_clk) begin
    if (!lrst_b) begin
      out_sh_q <= '0;
      dout_q   <= 1'b0;
      doe_q    <= 1'b0;
    end else if (act_q && !i_serial_frame_sync) begin
      if (cnt_q == FRM_LOAD_READ) begin
        // stale answer reads as zero
        out_sh_q <= (ack_sync_q[1] == rreq_tgl_q) ? hold_q : 16'h0000;
        dout_q   <= (ack_sync_q[1] == rreq_tgl_q) ? hold_q[15] : 1'b0;
        doe_q    <= 1'b1;
      end else if (cnt_q > FRM_LOAD_READ && cnt_q < FRM_DATA_LAST) begin
        out_sh_q <= {out_sh_q[14:0], 1'b0};
        dout_q   <= out_sh_q[14];
      end else if (cnt_q == FRM_DATA_LAST) begin
        dout_q   <= 1'b0;
        doe_q    <= zsel_sync_q[1];
      end else if (cnt_q == FRM_LAST) begin
        doe_q    <= 1'b0;
      end
    end else if (!act_q) begin
      doe_q  <= 1'b0;
      dout_q <= 1'b0;
    end
  end

  assign o_serial_data_output    = dout_q;
  assign o_serial_data_output_oe = doe_q;

endmodule

// ### bench/gei_sva.sv
/*
  port checker for the port-pin and edge-interrupt block.
  assumes frames open with a one-cycle sync on the link clock.
*/
`timescale 1ns/1ps
module gei_sva
  import gei_pkg::*;
(
  // clocks and reset
  input wire logic              i_sys_clk,
  input wire logic              i_rst_b,
  input wire logic              i_link_clk,
  // link
  input wire logic              i_serial_frame_sync,
  input wire logic              o_serial_data_output,
  input wire logic              o_serial_data_output_oe,
  // pins, sources, interrupt
  input wire logic [PORT_W-1:0] i_port_pin,
  input wire logic [PORT_W-1:0] o_port_pin_out,
  input wire logic [PORT_W-1:0] o_port_pin_oe,
  input wire logic              i_converter_done,
  input wire logic              i_touch_plus_x_sense,
  input wire logic              i_touch_minus_x_sense,
  input wire logic              i_telecom_clip,
  input wire logic              i_audio_clip,
  input wire logic              o_irq
);
  logic [6:0]  pos_q;
  logic [15:0] srcs;
  logic [1:0]  lrun_q;
  assign srcs = {i_audio_clip, i_telecom_clip, i_touch_minus_x_sense,
                 i_touch_plus_x_sense, i_converter_done, 1'b0, i_port_pin};

  // bit position within the frame, 64 when idle
  always_ff @(posedge i_link_clk) begin
    if (!i_rst_b)
      pos_q <= 7'h40;
    else if (i_serial_frame_sync)
      pos_q <= 7'h00;
    else if (pos_q < 7'h40)
      pos_q <= pos_q + 7'h01;
  end

  // link edges since reset release; the link side leaves reset late
  always_ff @(posedge i_link_clk) begin
    if (!i_rst_b)
      lrun_q <= 2'h0;
    else if (lrun_q != 2'h3)
      lrun_q <= lrun_q + 2'h1;
  end

  a_reset_quiet:
    assert property (@(posedge i_sys_clk) $past(!i_rst_b) |->
      o_port_pin_oe == '0 && o_port_pin_out == '0 && !o_irq)
    else $error("outputs not cleared by reset");
  a_head_release:
    assert property (@(posedge i_link_clk) disable iff (!i_rst_b)
      pos_q < 7'h0F |-> !o_serial_data_output_oe)
    else $error("serial out driven before word data");
  a_word_one_drive:
    assert property (@(posedge i_link_clk) disable iff (!i_rst_b)
      pos_q inside {[7'h0F:7'h1E]} |-> o_serial_data_output_oe)
    else $error("serial out not driven in read data");
  a_word_two_low:
    assert property (@(posedge i_link_clk) disable iff (!i_rst_b)
      pos_q inside {[7'h1F:7'h3E]} && o_serial_data_output_oe
      |-> !o_serial_data_output)
    else $error("serial out not low in second word");
  a_word_two_steady:
    assert property (@(posedge i_link_clk) disable iff (!i_rst_b)
      pos_q inside {[7'h20:7'h3E]} |-> $stable(o_serial_data_output_oe))
    else $error("serial out enable moved in second word");
  a_tail_release:
    assert property (@(posedge i_link_clk)
      disable iff (!i_rst_b || lrun_q != 2'h3)
      pos_q inside {[7'h3F:7'h40]} |-> !o_serial_data_output_oe)
    else $error("serial out driven after frame");
  a_dir_settled:
    assert property (@(posedge i_link_clk) disable iff (!i_rst_b)
      pos_q inside {[7'h0A:7'h3E]} |->
      $stable(o_port_pin_oe) && $stable(o_port_pin_out))
    else $error("port register changed before frame end");
  a_irq_cause:
    assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
      $rose(o_irq) |-> $past(srcs, 1) != $past(srcs, 8))
    else $error("interrupt raised with no source edge");

  c_irq_rise: cover property (@(posedge i_sys_clk) $rose(o_irq));
  c_irq_fall: cover property (@(posedge i_sys_clk) $fell(o_irq));
  c_zero_word: cover property (@(posedge i_link_clk)
    pos_q == 7'h28 && o_serial_data_output_oe);
endmodule

bind gei_top gei_sva u_sva (
  .i_sys_clk, .i_rst_b, .i_link_clk, .i_serial_frame_sync,
  .o_serial_data_output, .o_serial_data_output_oe, .i_port_pin,
  .o_port_pin_out, .o_port_pin_oe, .i_converter_done, .i_touch_plus_x_sense,
  .i_touch_minus_x_sense, .i_telecom_clip, .i_audio_clip, .o_irq
);

// ### bench/gei_ctrl_model.sv
/*
  serial controller model: makes the bit clock and runs 64-bit frames.
  assumes read data comes back MSB first during bits 16 to 31.
*/
`timescale 1ns/1ps
module gei_ctrl_model (
  // link
  output logic      o_link_clk,
  output logic      o_sync,
  output logic      o_din,
  input  wire logic i_dout,
  input  wire logic i_dout_oe
);
  logic [15:0] rd_q;
  logic        w2_oe_q;
  logic        w2_d_q;
  logic        line;

  // a released line reads as the inverse of the present data output value
  assign line = i_dout_oe ? i_dout : ~i_dout;

  // bit clock runs free, as on a continuous codec bus
  initial begin
    o_link_clk = 1'b0;
    o_sync = 1'b0;
    o_din = 1'b0;
    forever #16 o_link_clk = ~o_link_clk;
  end

  task automatic frame(input logic wr, input logic [3:0] a,
                       input logic [15:0] d);
    logic [63:0] f;
    f = {wr, a, 11'h000, d, 32'h0000_0000};
    for (int i = 0; i < 64; i++) begin
      @(posedge o_link_clk);
      #1;
      if (i > 15 && i < 32)
        rd_q = {rd_q[14:0], line};
      if (i == 40) begin
        w2_oe_q = i_dout_oe;
        w2_d_q = line;
      end
      o_sync = (i == 0);
      o_din = f[63-i];
    end
    @(posedge o_link_clk);
    #1;
    o_din = ~o_din;
  endtask
endmodule

// ### bench/tb.sv
/*
  testbench for the port-pin and edge-interrupt block.
  assumes the controller model in bench for all register frames.
*/
`timescale 1ns/1ps
module tb;
  import gei_pkg::*;
  logic              i_sys_clk;
  logic              i_rst_b;
  logic              link_clk;
  logic              sync;
  logic              din;
  logic              dout;
  logic              dout_oe;
  logic [PORT_W-1:0] pin_out;
  logic [PORT_W-1:0] pin_oe;
  logic [15:0]       src;
  logic              irq;
  wire  [PORT_W-1:0] pin_wire;
  int                fail_count = 0;
  int                n_compared = 0;
  assign pin_wire = (pin_oe & pin_out) | (~pin_oe & src[PORT_W-1:0]);

  gei_top dut (
    .i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_link_clk(link_clk),
    .i_serial_frame_sync(sync), .i_serial_data_in(din),
    .o_serial_data_output(dout), .o_serial_data_output_oe(dout_oe),
    .i_port_pin(pin_wire), .o_port_pin_out(pin_out), .o_port_pin_oe(pin_oe),
    .i_converter_done(src[11]), .i_touch_plus_x_sense(src[12]),
    .i_touch_minus_x_sense(src[13]), .i_telecom_clip(src[14]),
    .i_audio_clip(src[15]), .o_irq(irq)
  );
  gei_ctrl_model ctrl (
    .o_link_clk(link_clk), .o_sync(sync), .o_din(din),
    .i_dout(dout), .i_dout_oe(dout_oe)
  );

  initial begin
    i_sys_clk = 1'b0;
    forever #20 i_sys_clk = ~i_sys_clk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    ctrl.frame(1'b0, a, 16'h0000);
    chk(ctrl.rd_q, exp);
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    ctrl.frame(1'b1, a, d);
    repeat (8) @(posedge i_sys_clk);
  endtask
  task automatic set_src(input logic [15:0] v);
    @(posedge i_sys_clk);
    #1;
    src = v;
    repeat (8) @(posedge i_sys_clk);
  endtask

  task automatic t_reset;
    rd(REG_PORT_PIN_DIRECTION, 16'h0000);
    rd(REG_RISING_EDGE_ENABLE, 16'h0000);
    rd(REG_FALLING_EDGE_ENABLE, 16'h0000);
    rd(REG_INT_CLEAR_STATUS, 16'h0000);
    wr(4'h5, 16'hFFFF);
    rd(4'h5, 16'h0000);
  endtask
  task automatic t_port;
    set_src(16'h02AA);
    wr(REG_PORT_PIN_DIRECTION, 16'h800F);
    wr(REG_PORT_PIN_DATA, 16'h03F5);
    chk({6'h00, pin_oe}, 16'h000F);
    chk({6'h00, pin_out}, 16'h03F5);
    rd(REG_PORT_PIN_DATA, 16'h02A5);
    chk({14'h0000, ctrl.w2_oe_q, ctrl.w2_d_q}, 16'h0002);
    wr(REG_PORT_PIN_DIRECTION, 16'h7FFF);
    rd(REG_PORT_PIN_DIRECTION, 16'h03FF);
    chk({14'h0000, ctrl.w2_oe_q, ctrl.w2_d_q}, 16'h0001);
    wr(REG_PORT_PIN_DIRECTION, 16'h0000);
  endtask
  task automatic t_edges;
    set_src(16'h0000);
    wr(REG_RISING_EDGE_ENABLE, 16'hFFFF);
    rd(REG_RISING_EDGE_ENABLE, 16'hFBFF);
    set_src(16'hFFFF);
    rd(REG_INT_CLEAR_STATUS, 16'hFBFF);
    chk({15'h0000, irq}, 16'h0001);
    wr(REG_INT_CLEAR_STATUS, 16'h0000);
    rd(REG_INT_CLEAR_STATUS, 16'hFBFF);
    wr(REG_INT_CLEAR_STATUS, 16'hFBFF);
    rd(REG_INT_CLEAR_STATUS, 16'h0000);
    chk({15'h0000, irq}, 16'h0000);
    set_src(16'h0000);
    rd(REG_INT_CLEAR_STATUS, 16'h0000);
    wr(REG_RISING_EDGE_ENABLE, 16'h0000);
    wr(REG_FALLING_EDGE_ENABLE, 16'hFFFF);
    rd(REG_FALLING_EDGE_ENABLE, 16'hFBFF);
    set_src(16'hFFFF);
    rd(REG_INT_CLEAR_STATUS, 16'h0000);
    set_src(16'h0000);
    rd(REG_INT_CLEAR_STATUS, 16'hFBFF);
    wr(REG_INT_CLEAR_STATUS, 16'hFBFF);
    rd(REG_INT_CLEAR_STATUS, 16'hFBFF);
    wr(REG_INT_CLEAR_STATUS, 16'h0000);
    wr(REG_INT_CLEAR_STATUS, 16'h0800);
    rd(REG_INT_CLEAR_STATUS, 16'hF3FF);
    wr(REG_INT_CLEAR_STATUS, 16'hF800);
    rd(REG_INT_CLEAR_STATUS, 16'h03FF);
    wr(REG_INT_CLEAR_STATUS, 16'hFBFF);
    rd(REG_INT_CLEAR_STATUS, 16'h0000);
  endtask

  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial begin
    #300000;
    fail_count++;
    finish_test();
  end

  initial begin
    i_rst_b = 1'b0;
    src = 16'h0000;
    repeat (2) @(posedge i_sys_clk);
    #1;
    i_rst_b = 1'b1;
    repeat (4) @(posedge link_clk);
    t_reset();
    t_port();
    t_edges();
    finish_test();
  end
endmodule
